/* File: rtl/glyph_pkg.sv */
package glyph_pkg;
  localparam int CODE_W       = 8;
  localparam int ADDR_W       = 6;
  localparam int DATA_W       = 8;
  localparam int DOTS         = 5;
  localparam int LINE_W       = 4;
  localparam int RAM_DEPTH    = 64;
  localparam int USER_HI_LSB  = 4;
  localparam int ROW8_LAST    = 7;
  localparam int ROW10_CURSOR = 10;
  localparam logic [3:0] USER_HI_ZERO = 4'h0;
  localparam logic [4:0] DOTS_OFF     = 5'h00;
  localparam logic [4:0] DOTS_ALL     = 5'h1f;
endpackage

/* File: rtl/glyph_addr_map.sv */
`timescale 1ns/1ns
module glyph_addr_map
  import glyph_pkg::*;
(
  input  wire logic [CODE_W-1:0] char_code,
  input  wire logic [LINE_W-1:0] line,
  input  wire logic              font_5x10,
  output logic      [ADDR_W-1:0] addr,
  output logic                   user_sel,
  output logic                   cursor_row,
  output logic                   row_valid
);
  wire logic [ADDR_W-1:0] addr_5x8;
  wire logic [ADDR_W-1:0] addr_5x10;

  // Code bit 3 dropped; codes 00h and 08h alias
  assign addr_5x8   = {char_code[2:0], line[2:0]};
  // Code bits 0 and 3 dropped
  assign addr_5x10  = {char_code[2:1], line};
  assign addr       = font_5x10 ? addr_5x10 : addr_5x8;
  assign user_sel   = (char_code[7:USER_HI_LSB] == USER_HI_ZERO);
  assign cursor_row = font_5x10 ? (line == LINE_W'(ROW10_CURSOR))
                                : (line[2:0] == 3'(ROW8_LAST));
  assign row_valid  = font_5x10 ? (line <= LINE_W'(ROW10_CURSOR)) : 1'b1;
endmodule

/* File: rtl/user_glyph_ram_addressing.sv */
`timescale 1ns/1ns
// Contract
// - Pattern data bits 0..4 drive the five dot columns, bit 4 leftmost.
// - In 5x8 mode code bits 0..2 form pattern address bits 3..5, eight glyphs.
// - A one bit lights its dot and a zero bit leaves it dark.
// - In 5x8 mode address bits 0..2 come from the glyph line counter.
// - In 5x8 mode row eight is the cursor row, shown as pattern OR cursor.
// - A one in a cursor-row pattern bit lights its dot wherever the cursor is.
// - User pattern memory is used instead of font ROM when code bits 4..7 are zero.
// - In 5x8 mode code bit 3 is ignored, so 00h and 08h show the same glyph.
// - The host may rewrite patterns at any time and the new pattern is shown.
// - In 5x10 mode code bits 1 and 2 form address bits 4 and 5, four glyphs.
// - In 5x10 mode address bits 0..3 pick the row, row eleven is cursor OR pattern.
// - In 5x10 mode code bits 0 and 3 are ignored.
module user_glyph_ram_addressing
  import glyph_pkg::*;
#(
  parameter int DEPTH = RAM_DEPTH
)(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              font_5x10,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [CODE_W-1:0] char_code,
  input  wire logic [LINE_W-1:0] line,
  input  wire logic              cursor_on,
  input  wire logic [DOTS-1:0]   rom_dots,
  output logic      [DOTS-1:0]   dots,
  output logic                   from_user
);
  // One entry per address; any other depth leaves holes or dead rows
  if (DEPTH != RAM_DEPTH) begin : g_bad_depth
    $error("DEPTH must equal the 6-bit address space");
  end

  logic [DOTS-1:0] pattern_ram [DEPTH];

  wire logic [ADDR_W-1:0] rd_addr;
  wire logic              user_sel;
  wire logic              cursor_row;
  wire logic              row_valid;
  wire logic [DOTS-1:0]   ram_dots;
  wire logic [DOTS-1:0]   cursor_dots;
  wire logic [DOTS-1:0]   user_dots;
  wire logic [DOTS-1:0]   next_dots;

  // Decode used by the checks, kept apart from the address map
  function automatic logic is_user_code(input logic [CODE_W-1:0] code);
    is_user_code = (code[CODE_W-1:USER_HI_LSB] == USER_HI_ZERO);
  endfunction

  function automatic logic [ADDR_W-1:0] addr_of_5x8(input logic [CODE_W-1:0] code,
                                                    input logic [LINE_W-1:0] row);
    addr_of_5x8 = {code[2:0], row[2:0]};
  endfunction

  function automatic logic [ADDR_W-1:0] addr_of_5x10(input logic [CODE_W-1:0] code,
                                                     input logic [LINE_W-1:0] row);
    addr_of_5x10 = {code[2:1], row};
  endfunction

  wire logic              user_code;
  wire logic [CODE_W-1:0] code_flip3;
  wire logic [CODE_W-1:0] code_flip03;
  wire logic [ADDR_W-1:0] addr8;
  wire logic [ADDR_W-1:0] addr10;
  wire logic              last_row8;
  wire logic              cursor_row10;
  wire logic              past_rows10;
  wire logic [DOTS-1:0]   pat8;
  wire logic [DOTS-1:0]   pat10;

  glyph_addr_map u_map (
    .char_code  (char_code),
    .line       (line),
    .font_5x10  (font_5x10),
    .addr       (rd_addr),
    .user_sel   (user_sel),
    .cursor_row (cursor_row),
    .row_valid  (row_valid)
  );

  // Only bits 0..4 stored; upper data bits never reach the panel
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_ram
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          pattern_ram[gi] <= DOTS_OFF;
        end else if (wr_en && wr_addr == ADDR_W'(gi)) begin
          pattern_ram[gi] <= wr_data[DOTS-1:0];
        end
      end

      chk_ram_hold: assert property (
        @(posedge ref_clk) disable iff (rst)
        !(wr_en && wr_addr == ADDR_W'(gi)) |=> $stable(pattern_ram[gi]))
        else $error("pattern entry changed without a write");
    end
  endgenerate

  assign ram_dots    = row_valid ? pattern_ram[rd_addr] : DOTS_OFF;
  assign cursor_dots = (cursor_row && cursor_on) ? DOTS_ALL : DOTS_OFF;
  // Pattern bits stay visible on cursor row regardless of cursor
  assign user_dots   = ram_dots | cursor_dots;
  // Bit 4 is leftmost column, dots[4]
  assign next_dots   = user_sel ? user_dots : rom_dots;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dots      <= DOTS_OFF;
      from_user <= 1'b0;
    end else begin
      dots      <= next_dots;
      from_user <= user_sel;
    end
  end

  // Reference decode seen by the checks below
  assign user_code    = is_user_code(char_code);
  assign code_flip3   = {char_code[CODE_W-1:USER_HI_LSB], ~char_code[3], char_code[2:0]};
  assign code_flip03  = {char_code[CODE_W-1:USER_HI_LSB], ~char_code[3], char_code[2:1],
                         ~char_code[0]};
  assign addr8        = addr_of_5x8(char_code, line);
  assign addr10       = addr_of_5x10(char_code, line);
  assign last_row8    = (line[2:0] == 3'(ROW8_LAST));
  assign cursor_row10 = (line == LINE_W'(ROW10_CURSOR));
  assign past_rows10  = (line > LINE_W'(ROW10_CURSOR));
  assign pat8         = pattern_ram[addr8];
  assign pat10        = pattern_ram[addr10];

  // Code select and ROM path
  chk_user_select: assert property (
    @(posedge ref_clk) disable iff (rst)
    1'b1
      |=> from_user == $past(user_code))
    else $error("user select wrong");

  chk_rom_path: assert property (
    @(posedge ref_clk) disable iff (rst)
    !user_code
      |=> dots == $past(rom_dots))
    else $error("rom dots not passed");

  // 5x8 mapping
  chk_addr_5x8: assert property (
    @(posedge ref_clk) disable iff (rst)
    !font_5x10
      |-> rd_addr == addr8 && row_valid)
    else $error("5x8 address wrong");

  chk_alias_bit3: assert property (
    @(posedge ref_clk) disable iff (rst)
    !font_5x10
      |-> rd_addr == addr_of_5x8(code_flip3, line))
    else $error("5x8 address depends on code bit 3");

  chk_lookup_5x8: assert property (
    @(posedge ref_clk) disable iff (rst)
    (!font_5x10 && user_code && !cursor_on)
      |=> dots == $past(pat8))
    else $error("5x8 lookup wrong");

  chk_column_left: assert property (
    @(posedge ref_clk) disable iff (rst)
    (!font_5x10 && user_code && !cursor_on)
      |=> dots[DOTS-1] == $past(pat8[DOTS-1]))
    else $error("leftmost column wrong");

  chk_dark_bits: assert property (
    @(posedge ref_clk) disable iff (rst)
    (!font_5x10 && user_code && !cursor_on && pat8 == DOTS_OFF)
      |=> dots == DOTS_OFF)
    else $error("zero pattern lit");

  chk_cursor_or: assert property (
    @(posedge ref_clk) disable iff (rst)
    (!font_5x10 && user_code && last_row8 && cursor_on)
      |=> dots == DOTS_ALL)
    else $error("cursor row not lit");

  chk_pattern_kept: assert property (
    @(posedge ref_clk) disable iff (rst)
    (!font_5x10 && user_code && last_row8)
      |=> (dots & $past(pat8)) == $past(pat8))
    else $error("cursor row pattern lost");

  // 5x10 mapping
  chk_addr_5x10: assert property (
    @(posedge ref_clk) disable iff (rst)
    font_5x10
      |-> rd_addr == addr10)
    else $error("5x10 address wrong");

  chk_ignore_bits03: assert property (
    @(posedge ref_clk) disable iff (rst)
    font_5x10
      |-> rd_addr == addr_of_5x10(code_flip03, line))
    else $error("5x10 address depends on code bits 0 or 3");

  chk_lookup_5x10: assert property (
    @(posedge ref_clk) disable iff (rst)
    (font_5x10 && user_code && !cursor_on && !past_rows10)
      |=> dots == $past(pat10))
    else $error("5x10 lookup wrong");

  chk_cursor_10: assert property (
    @(posedge ref_clk) disable iff (rst)
    (font_5x10 && user_code && cursor_row10 && cursor_on)
      |=> dots == DOTS_ALL)
    else $error("5x10 cursor row not lit");

  chk_rows_unused: assert property (
    @(posedge ref_clk) disable iff (rst)
    (font_5x10 && user_code && past_rows10)
      |=> dots == DOTS_OFF)
    else $error("unused row lit");

  // Write path
  chk_write_seen: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_en
      |=> pattern_ram[$past(wr_addr)] == $past(wr_data[DOTS-1:0]))
    else $error("pattern write lost");
endmodule

/* File: verification/host_mpu.sv */
`timescale 1ns/1ns
module host_mpu
  import glyph_pkg::*;
(
  input  wire logic              ref_clk,
  output logic                   wr_en,
  output logic      [ADDR_W-1:0] wr_addr,
  output logic      [DATA_W-1:0] wr_data
);
  initial wr_en = 1'b0;
  initial wr_addr = '0;
  initial wr_data = '0;
  task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk) #1;
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge ref_clk) #1;
    wr_en = 1'b0;
    wr_data = ~d;
  endtask
endmodule

/* File: verification/user_glyph_ram_addressing_bench.sv */
`timescale 1ns/1ns
module user_glyph_ram_addressing_bench
  import glyph_pkg::*;
;
  logic              ref_clk, rst, font_5x10, cursor_on, wr_en, from_user;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [CODE_W-1:0] char_code;
  logic [LINE_W-1:0] line;
  logic [DOTS-1:0]   rom_dots, dots;
  int                failures = 0, total_checks = 0;
  user_glyph_ram_addressing dut (.ref_clk(ref_clk), .rst(rst), .font_5x10(font_5x10),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .char_code(char_code), .line(line),
    .cursor_on(cursor_on), .rom_dots(rom_dots), .dots(dots), .from_user(from_user));
  host_mpu host (.ref_clk(ref_clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic look(input logic f, input logic [7:0] c, input logic [3:0] l,
                      input logic cur, input logic [4:0] e, input logic u);
    @(posedge ref_clk) #1;
    font_5x10 = f;
    char_code = c;
    line = l;
    cursor_on = cur;
    @(posedge ref_clk) #1;
    total_checks++;
    if (dots !== e || from_user !== u) begin
      failures++;
      $display("wrong value dots/from_user expected %h/%b seen %h/%b", e, u, dots, from_user);
    end
  endtask
  task automatic s_map8();
    host.write(6'h2b, 8'he6);
    look(1'b0, 8'h0d, 4'h3, 1'b0, 5'h06, 1'b1);
    look(1'b0, 8'h05, 4'h3, 1'b0, 5'h06, 1'b1);
    look(1'b0, 8'h05, 4'h2, 1'b0, 5'h00, 1'b1);
    look(1'b0, 8'h15, 4'h3, 1'b0, 5'h0a, 1'b0);
  endtask
  task automatic s_cursor8();
    host.write(6'h2f, 8'h00);
    look(1'b0, 8'h05, 4'h7, 1'b1, 5'h1f, 1'b1);
    look(1'b0, 8'h05, 4'h7, 1'b0, 5'h00, 1'b1);
    host.write(6'h2f, 8'h11);
    look(1'b0, 8'h05, 4'h7, 1'b0, 5'h11, 1'b1);
  endtask
  task automatic s_map10();
    host.write(6'h29, 8'h11);
    host.write(6'h2c, 8'h1f);
    look(1'b1, 8'h0c, 4'h9, 1'b0, 5'h11, 1'b1);
    look(1'b1, 8'h05, 4'h9, 1'b0, 5'h11, 1'b1);
    look(1'b1, 8'h0c, 4'ha, 1'b1, 5'h1f, 1'b1);
    look(1'b1, 8'h0c, 4'ha, 1'b0, 5'h00, 1'b1);
    look(1'b1, 8'h0c, 4'hc, 1'b0, 5'h00, 1'b1);
  endtask
  task automatic s_rom();
    rom_dots = 5'h15;
    look(1'b0, 8'h41, 4'h2, 1'b0, 5'h15, 1'b0);
    rom_dots = 5'h0b;
    look(1'b1, 8'hf8, 4'h0, 1'b0, 5'h0b, 1'b0);
  endtask
  task automatic s_reset();
    host.write(6'h2b, 8'h1f);
    look(1'b0, 8'h05, 4'h3, 1'b0, 5'h1f, 1'b1);
    @(posedge ref_clk) #1;
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    look(1'b0, 8'h05, 4'h3, 1'b0, 5'h00, 1'b1);
  endtask
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    results();
  end
  initial begin
    rst = 1'b1;
    font_5x10 = 1'b0;
    char_code = 8'h20;
    line = 4'h0;
    cursor_on = 1'b0;
    rom_dots = 5'h0a;
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    s_map8();
    s_cursor8();
    s_map10();
    s_rom();
    s_reset();
    results();
  end
endmodule
